// [msc_pkg.sv]
// package for the mac statistics counter block: dump offsets, widths, commands
// assumes one system clock and no software-visible registers
package msc_pkg;
  localparam int CNT_W = 32;
  localparam int NUM_CNT = 12;
  // snapshot byte offsets
  localparam logic [7:0] OFF_TX_GOOD = 8'h00;
  localparam logic [7:0] OFF_TX_MAX_COLLISION_ABORT = 8'h04;
  localparam logic [7:0] OFF_TX_LATE_COLLISION_ABORT = 8'h08;
  localparam logic [7:0] OFF_TX_UNDERRUN = 8'h0c;
  localparam logic [7:0] OFF_TX_LOSTCRS = 8'h10;
  localparam logic [7:0] OFF_TX_DEFER = 8'h14;
  localparam logic [7:0] OFF_TX_SINGLE = 8'h18;
  localparam logic [7:0] OFF_TX_MULTI = 8'h1c;
  localparam logic [7:0] OFF_TX_TOTCOL = 8'h20;
  localparam logic [7:0] OFF_RX_GOOD = 8'h24;
  localparam logic [7:0] OFF_RX_CRC = 8'h28;
  localparam logic [7:0] OFF_RX_ALIGN = 8'h2c;
  localparam logic [7:0] OFF_WORD_STEP = 8'h04;
  // counter indices
  localparam int IX_TX_GOOD = 0;
  localparam int IX_TX_MAX_COLLISION_ABORT = 1;
  localparam int IX_TX_LATE_COLLISION_ABORT = 2;
  localparam int IX_TX_UNDERRUN = 3;
  localparam int IX_TX_LOSTCRS = 4;
  localparam int IX_TX_DEFER = 5;
  localparam int IX_TX_SINGLE = 6;
  localparam int IX_TX_MULTI = 7;
  localparam int IX_TX_TOTCOL = 8;
  localparam int IX_RX_GOOD = 9;
  localparam int IX_RX_CRC = 10;
  localparam int IX_RX_ALIGN = 11;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [3:0] IDX_LAST = 4'hb;
  // command_unit_command_field codes
  localparam logic [3:0] CUC_DUMP = 4'h5;
  localparam logic [3:0] CUC_DUMP_RESET = 4'h7;
  typedef enum logic [2:0] {
    MSC_IDLE = 3'b001,
    MSC_DUMP = 3'b010,
    MSC_DONE = 3'b100
  } msc_state_t;
endpackage

// [msc_stat_counters.sv]
// mac statistics counters with snapshot dump to host memory
// assumes event strobes and commands come from same-clock mac/command logic
// Summary of operation
// - counters other than underrun and total collisions update only when a frame's transmit or receive processing is done
// - counters are reported only on dump or dump-and-reset commands
// - transmit good frames, offset 0, counted after wire transmission completes
// - offset 4 counts frames aborted at maximum collisions
// - offset 8 counts frames aborted on late collision
// - offset 12 counts underruns, possibly several per frame
// - offset 16 counts frames sent with lost carrier sense
// - offset 20 counts frames deferred for link activity
// - offset 24 counts good frames with exactly one collision
// - offset 28 counts good frames with two or more collisions
// - offset 32 sums every transmit collision including late and max
// - offset 36 counts received frames fully stored in memory with no crc error and not short
// - offset 40 counts aligned crc-error frames in any receive state
// - offset 44 counts misaligned crc-error frames in any receive state
// - at most one of crc, alignment counters per received frame
// - counters are 32 bits and wrap to zero
// - counters clear at reset, no preset possible
// - one frame may bump several counters
`timescale 1ns/10ps
module msc_stat_counters (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // transmit completion
  input wire logic txDone,
  input wire logic txGood,
  input wire logic txMaxColAbort,
  input wire logic txLateColAbort,
  input wire logic txLostCrs,
  input wire logic txDeferred,
  input wire logic [4:0] txColCount,
  input wire logic txUnderrun,
  input wire logic txColPulse,
  // receive completion
  input wire logic rxDone,
  input wire logic rxStored,
  input wire logic rxCrcErr,
  input wire logic rxMisaligned,
  input wire logic rxShort,
  // command unit
  input wire logic cmdValid,
  input wire logic [3:0] cmdCode,
  input wire logic dumpReady,
  // snapshot write port
  output logic dumpValid,
  output logic [7:0] dumpOffset,
  output logic [31:0] dumpData,
  output logic dumpDone,
  output logic cmdBusy
);
  msc_pkg::msc_state_t state;
  msc_pkg::msc_state_t next_state;
  logic [31:0] cnt [msc_pkg::NUM_CNT];
  logic [3:0] idx;
  logic clearAfter;
  logic [msc_pkg::NUM_CNT-1:0] inc;
  wire txFrame = clkEn && txDone;
  wire rxFrame = clkEn && rxDone;
  wire rxShortOnly = rxShort;
  wire rxCrcOnly = rxCrcErr && !rxMisaligned && !rxShort;
  wire rxAlignOnly = rxCrcErr && rxMisaligned && !rxShort;
  wire cmdDump = cmdValid && (cmdCode == msc_pkg::CUC_DUMP);
  wire cmdDumpRst = cmdValid && (cmdCode == msc_pkg::CUC_DUMP_RESET);
  wire startDump = (state == msc_pkg::MSC_IDLE) && (cmdDump || cmdDumpRst);
  wire wordTaken = dumpValid && dumpReady;
  wire lastWord = wordTaken && (idx == msc_pkg::IDX_LAST);

  // byte offset of each counter in the snapshot image
  logic [7:0] offTab [msc_pkg::NUM_CNT];
  assign offTab[msc_pkg::IX_TX_GOOD] = msc_pkg::OFF_TX_GOOD;
  assign offTab[msc_pkg::IX_TX_MAX_COLLISION_ABORT] = msc_pkg::OFF_TX_MAX_COLLISION_ABORT;
  assign offTab[msc_pkg::IX_TX_LATE_COLLISION_ABORT] = msc_pkg::OFF_TX_LATE_COLLISION_ABORT;
  assign offTab[msc_pkg::IX_TX_UNDERRUN] = msc_pkg::OFF_TX_UNDERRUN;
  assign offTab[msc_pkg::IX_TX_LOSTCRS] = msc_pkg::OFF_TX_LOSTCRS;
  assign offTab[msc_pkg::IX_TX_DEFER] = msc_pkg::OFF_TX_DEFER;
  assign offTab[msc_pkg::IX_TX_SINGLE] = msc_pkg::OFF_TX_SINGLE;
  assign offTab[msc_pkg::IX_TX_MULTI] = msc_pkg::OFF_TX_MULTI;
  assign offTab[msc_pkg::IX_TX_TOTCOL] = msc_pkg::OFF_TX_TOTCOL;
  assign offTab[msc_pkg::IX_RX_GOOD] = msc_pkg::OFF_RX_GOOD;
  assign offTab[msc_pkg::IX_RX_CRC] = msc_pkg::OFF_RX_CRC;
  assign offTab[msc_pkg::IX_RX_ALIGN] = msc_pkg::OFF_RX_ALIGN;

  // snapshot sequencing; a dump-and-reset clears each counter as its word is captured
  wire next_clearAfter = startDump ? cmdDumpRst : clearAfter;
  wire [3:0] next_idx = startDump ? 4'h0 : (wordTaken ? idx + 4'h1 : idx);
  wire [3:0] rdIdx = (next_idx > msc_pkg::IDX_LAST) ? msc_pkg::IDX_LAST : next_idx;
  wire loadWord = clkEn && (startDump || (wordTaken && !lastWord));

  // next values of the registered outputs
  wire next_dumpValid = loadWord || (dumpValid && !wordTaken);
  wire next_dumpDone = (state == msc_pkg::MSC_DUMP) && lastWord;
  wire next_cmdBusy = (next_state == msc_pkg::MSC_DUMP);
  wire [7:0] next_dumpOffset = offTab[rdIdx];
  wire [31:0] next_dumpData = cnt[rdIdx];

  // per-counter increment decode; several may fire for one frame
  assign inc[msc_pkg::IX_TX_GOOD] = txFrame && txGood;
  assign inc[msc_pkg::IX_TX_MAX_COLLISION_ABORT] = txFrame && txMaxColAbort;
  assign inc[msc_pkg::IX_TX_LATE_COLLISION_ABORT] = txFrame && txLateColAbort;
  assign inc[msc_pkg::IX_TX_UNDERRUN] = clkEn && txUnderrun;
  assign inc[msc_pkg::IX_TX_LOSTCRS] = txFrame && txGood && txLostCrs;
  assign inc[msc_pkg::IX_TX_DEFER] = txFrame && txDeferred;
  assign inc[msc_pkg::IX_TX_SINGLE] = txFrame && txGood && (txColCount == 5'h01);
  assign inc[msc_pkg::IX_TX_MULTI] = txFrame && txGood && (txColCount > 5'h01);
  assign inc[msc_pkg::IX_TX_TOTCOL] = clkEn && txColPulse;
  assign inc[msc_pkg::IX_RX_GOOD] = rxFrame && rxStored && !rxCrcErr && !rxShortOnly;
  assign inc[msc_pkg::IX_RX_CRC] = rxFrame && rxCrcOnly;
  assign inc[msc_pkg::IX_RX_ALIGN] = rxFrame && rxAlignOnly;
  // counters wrap; a cleared counter restarts from the event of its capture cycle
  for (genvar i = 0; i < msc_pkg::NUM_CNT; i++) begin : g_cnt
    // no event is lost: the old value goes out in the word, the new one stays
    wire clearWord = loadWord && next_clearAfter && (next_idx == 4'(i));
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt[i] <= msc_pkg::CNT_RESET;
      end else if (clearWord) begin
        cnt[i] <= {31'h0000_0000, inc[i]};
      end else if (inc[i]) begin
        cnt[i] <= cnt[i] + 32'h0000_0001;
      end
    end
  end
  always_comb begin
    next_state = state;
    unique case (state)
      msc_pkg::MSC_IDLE: begin
        if (startDump) begin
          next_state = msc_pkg::MSC_DUMP;
        end
      end
      msc_pkg::MSC_DUMP: begin
        if (lastWord) begin
          next_state = msc_pkg::MSC_DONE;
        end
      end
      msc_pkg::MSC_DONE: begin
        next_state = msc_pkg::MSC_IDLE;
      end
      default: begin
        next_state = msc_pkg::MSC_IDLE;
      end
    endcase
  end

  // sequencer state, frozen while clkEn is low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= msc_pkg::MSC_IDLE;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // word index of the snapshot
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx <= 4'h0;
    end else if (clkEn) begin
      idx <= next_idx;
    end
  end

  // dump mode latched at command acceptance
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clearAfter <= 1'b0;
    end else if (clkEn) begin
      clearAfter <= next_clearAfter;
    end
  end

  // snapshot port: a word stands until it is taken
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dumpValid <= 1'b0;
    end else if (clkEn) begin
      dumpValid <= next_dumpValid;
    end
  end

  // offset and data are captured together when a word is loaded
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dumpOffset <= 8'h00;
    end else if (loadWord) begin
      dumpOffset <= next_dumpOffset;
    end
  end

  // data is the counter value before any clear of the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dumpData <= msc_pkg::CNT_RESET;
    end else if (loadWord) begin
      dumpData <= next_dumpData;
    end
  end

  // status outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dumpDone <= 1'b0;
    end else if (clkEn) begin
      dumpDone <= next_dumpDone;
    end
  end

  // busy only while words are outstanding
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdBusy <= 1'b0;
    end else if (clkEn) begin
      cmdBusy <= next_cmdBusy;
    end
  end
endmodule

// [msc_stat_counters_props.sv]
// checker for the snapshot handshake and command handling
// assumes one clock; bound to the counter block
`timescale 1ns/10ps
module msc_stat_counters_props (
  // clock
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // command and snapshot
  input wire logic cmdValid,
  input wire logic [3:0] cmdCode,
  input wire logic dumpReady,
  input wire logic dumpValid,
  input wire logic [7:0] dumpOffset,
  input wire logic [31:0] dumpData,
  input wire logic dumpDone,
  input wire logic cmdBusy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence lastWord;
    clkEn && dumpValid && dumpReady && dumpOffset == msc_pkg::OFF_RX_ALIGN;
  endsequence
  start_dump_a: assert property (clkEn && cmdValid && (cmdCode == msc_pkg::CUC_DUMP_RESET
    || cmdCode == msc_pkg::CUC_DUMP) && !cmdBusy && !dumpDone
    |=> dumpValid && cmdBusy && dumpOffset == msc_pkg::OFF_TX_GOOD) else $error("no start");
  word_step_a: assert property (clkEn && dumpValid && dumpReady && dumpOffset != msc_pkg::OFF_RX_ALIGN
    |=> dumpValid && dumpOffset == $past(dumpOffset) + msc_pkg::OFF_WORD_STEP) else $error("bad step");
  last_word_a: assert property (lastWord |=> dumpDone && !dumpValid && !cmdBusy) else $error("no done");
  word_hold_a: assert property (dumpValid && !dumpReady
    |=> dumpValid && $stable(dumpOffset) && $stable(dumpData)) else $error("word moved");
  done_pulse_a: assert property (clkEn && dumpDone |=> !dumpDone) else $error("long done");
  busy_flag_a: assert property (dumpValid |-> cmdBusy) else $error("not busy");
  bad_code_a: assert property (cmdValid && cmdCode == 4'h3 && !cmdBusy |=> !cmdBusy) else $error("took code");
  reset_idle_a: assert property ($rose(arst_n) |-> !dumpValid && !cmdBusy) else $error("busy at reset");
endmodule
bind msc_stat_counters msc_stat_counters_props p (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn),
  .cmdValid(cmdValid),
  .cmdCode(cmdCode), .dumpReady(dumpReady), .dumpValid(dumpValid), .dumpOffset(dumpOffset),
  .dumpData(dumpData), .dumpDone(dumpDone), .cmdBusy(cmdBusy));

// [msc_mem_model.sv]
// memory side: takes snapshot words, stalls at random when slow
// assumes the block's clock
`timescale 1ns/10ps
module msc_mem_model (
  // clock
  input wire logic sys_clk,
  input wire logic slow,
  // snapshot port
  input wire logic dumpValid,
  input wire logic [7:0] dumpOffset,
  input wire logic [31:0] dumpData,
  output logic dumpReady
);
  logic [31:0] got [12];
  logic [7:0] s = 8'h5a;
  initial dumpReady = 1'b0;
  always @(posedge sys_clk) begin
    if (dumpValid && dumpReady) got[dumpOffset[5:2]] <= dumpData;
    s <= {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    dumpReady <= #5 ~slow | s[0];
  end
endmodule

// [msc_stat_counters_tb.sv]
// self-checking bench for the statistics counters
// assumes the memory model and checker files
`timescale 1ns/10ps
module msc_stat_counters_tb;
  logic sys_clk = 1'b0, arst_n = 1'b0, cmdValid = 1'b0, slow = 1'b0, clkEn = 1'b1;
  logic [3:0] cmdCode = 4'h0;
  logic [31:0] r = 32'hd, ev = 32'h0, ex [12];
  int n_fail = 0, n_tests = 0, cyc = 0;
  wire logic dumpReady, dumpValid, dumpDone, cmdBusy;
  wire logic [7:0] dumpOffset;
  wire logic [31:0] dumpData;
  msc_stat_counters uut (.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .txDone(ev[0]), .txGood(ev[1]),
    .txMaxColAbort(ev[2] & ~ev[1]), .txLateColAbort(ev[3] & ~ev[1] & ~ev[2]), .txLostCrs(ev[4]),
    .txDeferred(ev[5]), .txColCount(ev[10:6]), .txUnderrun(ev[11]), .txColPulse(ev[12]), .rxDone(ev[13]),
    .rxStored(ev[14]), .rxCrcErr(ev[15]), .rxMisaligned(ev[16]), .rxShort(ev[17]), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .dumpReady(dumpReady), .dumpValid(dumpValid), .dumpOffset(dumpOffset),
    .dumpData(dumpData), .dumpDone(dumpDone), .cmdBusy(cmdBusy));
  msc_mem_model mem (.sys_clk(sys_clk), .slow(slow), .dumpValid(dumpValid), .dumpOffset(dumpOffset),
    .dumpData(dumpData), .dumpReady(dumpReady));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  function logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function void upd(logic [31:0] e);
    logic g;
    logic v;
    g = e[0] & e[1];
    v = e[13] & ~e[17];
    ex[0] += g;
    ex[1] += e[0] & e[2] & ~e[1];
    ex[2] += e[0] & e[3] & ~e[1] & ~e[2];
    ex[3] += e[11];
    ex[4] += g & e[4];
    ex[5] += e[0] & e[5];
    ex[6] += g & (e[10:6] == 5'h01);
    ex[7] += g & (e[10:6] > 5'h01);
    ex[8] += e[12];
    ex[9] += v & e[14] & ~e[15];
    ex[10] += v & e[15] & ~e[16];
    ex[11] += v & e[15] & e[16];
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic dump(logic [3:0] c);
    cmdCode = 4'h3;
    cmdValid = 1'b1;
    @(posedge sys_clk);
    #5 chk(cmdBusy, 1'b0);
    cmdCode = c;
    repeat (2) @(posedge sys_clk);
    #5 cmdValid = 1'b0;
    repeat (300) begin
      @(posedge sys_clk);
      #5 if (dumpDone === 1'b1) break;
    end
    chk(dumpDone, 1'b1);
    foreach (ex[i]) chk(mem.got[i], ex[i]);
    if (c == 4'h7) foreach (ex[i]) ex[i] = 32'h0;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    foreach (ex[i]) ex[i] = 32'h0;
    repeat (4) @(posedge sys_clk);
    #5 arst_n = 1'b1;
    dump(4'h7);
    for (int k = 0; k < 6; k++) begin
      slow = k[0];
      repeat (40) begin
        @(posedge sys_clk);
        #5 r = nx(r);
        ev = r;
        clkEn = r[20] | r[21];
        if (clkEn) upd(r);
      end
      @(posedge sys_clk);
      #5 ev = 32'h0;
      clkEn = 1'b1;
      dump(k[1] ? 4'h5 : 4'h7);
    end
    @(posedge sys_clk);
    #5 ev = 32'h0000_1800;
    @(posedge sys_clk);
    #5 ev = 32'h0;
    arst_n = 1'b0;
    foreach (ex[i]) ex[i] = 32'h0;
    repeat (2) @(posedge sys_clk);
    #5 arst_n = 1'b1;
    dump(4'h5);
    stop_test();
  end
endmodule
